// ---- rtl/io_channel_pkg.sv ----
// Purpose: constants and types shared by the i/o channel initiator
// Assumes: 30-bit memory words, two-bit character positions within a word
// Notes: instruction and control word layouts, instruction timing counts
package io_channel_pkg;
    localparam int word_w = 30;
    localparam int chan_n = 16;
    localparam int chan_w = 4;
    localparam int dev_w = 4;
    localparam int addr_w = 16;
    localparam int char_addr_w = 18;
    localparam int len_w = 12;
    localparam int max_block_len = 4096;
    // instruction fields
    localparam int ins_chan_lsb = 20;
    localparam int ins_ind_bit = 19;
    localparam int ins_idx_lsb = 16;
    localparam int ins_idx_w = 3;
    localparam int ins_addr_lsb = 0;
    localparam logic [2:0] idx_none = 3'h0;
    localparam logic [2:0] idx_void = 3'h1;
    // command word fields
    localparam int cmd_dev_lsb = 24;
    localparam int cmd_op_lsb = 14;
    localparam int cmd_op_w = 10;
    // block control word fields
    localparam int bcw_len_lsb = 18;
    localparam int bcw_addr_lsb = 0;
    // pc steps
    localparam logic [15:0] pc_step_busy = 16'h0001;
    localparam logic [15:0] pc_step_ok = 16'h0002;
    // instruction timings in time units, and cycles per unit
    localparam int save_units = 3;
    localparam int halt_units = 1;
    localparam int unit_ns = 1000;
    localparam int clk_ns = 5;
    localparam int unit_cycles = (unit_ns + clk_ns - 1) / clk_ns;
    localparam int save_cycles = save_units * unit_cycles;
    localparam int halt_cycles = halt_units * unit_cycles;
    typedef enum logic [2:0] {
        st_idle = 3'h0,
        st_ind = 3'h1,
        st_cmd = 3'h3,
        st_bcw = 3'h2,
        st_save0 = 3'h6,
        st_save1 = 3'h7,
        st_wait = 3'h5
    } seq_t;
endpackage

// ---- rtl/io_channel_initiator.sv ----
// Purpose: processor side i/o channel start, save and abort sequencer
// Assumes: memory port grants one word access per cycle when mem_grant high
// Notes: data moves word at a time; character count steps per character
//
// Chosen here: the address-and-strobe port.
`timescale 1ns/10ps
module io_channel_initiator
    import io_channel_pkg::*;
(
    // clock, reset, enable
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic clk_en,
    // instruction request
    input wire logic start_channel_transfer,
    input wire logic save_channel_registers,
    input wire logic abort_channel_transfer,
    input wire logic [word_w-1:0] instr_word,
    input wire logic [15:0] instr_pc,
    input wire logic [15:0] index_value,
    output logic instr_done,
    output logic [15:0] next_pc,
    // core memory port
    output logic mem_req,
    output logic mem_we,
    output logic [addr_w-1:0] mem_addr,
    output logic [word_w-1:0] mem_wdata,
    input wire logic mem_grant,
    input wire logic [word_w-1:0] mem_rdata,
    // channel side, per channel
    output logic [chan_n-1:0] chan_busy,
    output logic [chan_n*dev_w-1:0] chan_device,
    output logic [chan_n*cmd_op_w-1:0] chan_opcode,
    output logic [chan_n*char_addr_w-1:0] chan_addr,
    output logic [chan_n-1:0] chan_abort,
    input wire logic [chan_n-1:0] chan_counted,
    input wire logic [chan_n-1:0] chan_char,
    input wire logic [chan_n-1:0] chan_word_access,
    input wire logic [chan_n-1:0] chan_end,
    // interrupts
    input wire logic [chan_n-1:0] irq_mask_wr,
    input wire logic irq_mask_we,
    input wire logic [chan_n-1:0] irq_clear,
    output logic [chan_n-1:0] irq_status,
    output logic irq
);
    typedef struct packed {
        seq_t seq;
        logic [chan_w-1:0] sel;
        logic [addr_w-1:0] ptr;
        logic [15:0] wait_cnt;
        logic [15:0] pc_base;
        logic done;
        logic [15:0] pc_out;
        logic req;
        logic we;
        logic [addr_w-1:0] addr;
        logic [word_w-1:0] wdata;
        logic [chan_n-1:0] busy;
        logic [chan_n-1:0] abort;
        logic [chan_n-1:0][word_w-1:0] cmd;
        logic [chan_n-1:0][len_w:0] count;
        logic [chan_n-1:0][char_addr_w-1:0] caddr;
        logic [chan_n-1:0] flag;
        logic [chan_n-1:0] mask;
        logic irq;
    } state_t;

    state_t s, next_s;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [addr_w-1:0] eff_addr(input logic [word_w-1:0] w, input logic [15:0] ix);
        logic [addr_w-1:0] a;
        a = w[ins_addr_lsb +: addr_w];
        // index field value one carries no meaning
        if (w[ins_idx_lsb +: ins_idx_w] != idx_none && w[ins_idx_lsb +: ins_idx_w] != idx_void) begin
            a = a + ix;
        end
        return a;
    endfunction

    function automatic logic [word_w-1:0] pack_bcw(input logic [len_w:0] n, input logic [char_addr_w-1:0] a);
        logic [word_w-1:0] w;
        w = '0;
        w[bcw_len_lsb +: len_w] = n[len_w-1:0];
        w[bcw_addr_lsb +: char_addr_w] = a;
        return w;
    endfunction

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        logic [chan_w-1:0] c;
        logic [len_w:0] ln;
        logic [chan_n-1:0] done_evt;
        logic loading;
        c = '0;
        ln = '0;
        done_evt = '0;
        // a channel still being loaded must not count down or finish on stale words
        loading = (s.seq == st_ind) || (s.seq == st_cmd) || (s.seq == st_bcw);
        next_s = s;
        next_s.done = 1'b0;
        next_s.abort = '0;
        // per-channel transfer bookkeeping runs every cycle beside the program
        for (int i = 0; i < chan_n; i++) begin
            if (s.busy[i] && !(loading && s.sel == chan_w'(i))) begin
                if (chan_word_access[i]) begin
                    next_s.caddr[i] = s.caddr[i] + 18'h00004;
                end
                if (chan_counted[i] && chan_char[i] && s.count[i] != '0) begin
                    next_s.count[i] = s.count[i] - 13'h0001;
                end
                if (chan_end[i] || (chan_counted[i] && s.count[i] == '0)) begin
                    next_s.busy[i] = 1'b0;
                    done_evt[i] = 1'b1;
                end
            end
        end
        if (irq_mask_we) begin
            next_s.mask = irq_mask_wr;
        end
        unique case (s.seq)
            st_idle: begin
                next_s.req = 1'b0;
                next_s.we = 1'b0;
                c = instr_word[ins_chan_lsb +: chan_w];
                next_s.sel = c;
                next_s.pc_base = instr_pc;
                // index offset alone, kept for the indirect step
                next_s.ptr = eff_addr({instr_word[word_w-1:addr_w], addr_w'(0)}, index_value);
                if (start_channel_transfer) begin
                    if (s.busy[c]) begin
                        next_s.done = 1'b1;
                        next_s.pc_out = instr_pc + pc_step_busy;
                    end else begin
                        next_s.req = 1'b1;
                        next_s.addr = instr_word[ins_addr_lsb +: addr_w];
                        next_s.seq = instr_word[ins_ind_bit] ? st_ind : st_cmd;
                        if (!instr_word[ins_ind_bit]) begin
                            next_s.addr = eff_addr(instr_word, index_value);
                        end
                        next_s.busy[c] = 1'b1;
                    end
                end else if (save_channel_registers) begin
                    next_s.req = 1'b1;
                    next_s.we = 1'b1;
                    next_s.addr = eff_addr(instr_word, index_value);
                    next_s.wdata = s.cmd[c];
                    next_s.wait_cnt = 16'(save_cycles - 1);
                    next_s.seq = st_save0;
                end else if (abort_channel_transfer) begin
                    next_s.busy[c] = 1'b0;
                    next_s.abort[c] = 1'b1;
                    next_s.cmd[c] = '0;
                    next_s.count[c] = '0;
                    next_s.caddr[c] = '0;
                    next_s.wait_cnt = 16'(halt_cycles - 1);
                    next_s.seq = st_wait;
                end
            end
            st_ind: begin
                if (mem_grant) begin
                    // indirect word holds the address, indexing applied after
                    next_s.addr = mem_rdata[addr_w-1:0] + s.ptr;
                    next_s.seq = st_cmd;
                end
            end
            st_cmd: begin
                if (mem_grant) begin
                    next_s.cmd[s.sel] = mem_rdata;
                    next_s.addr = s.addr + 16'h0001;
                    next_s.seq = st_bcw;
                end
            end
            st_bcw: begin
                if (mem_grant) begin
                    ln = {1'b0, mem_rdata[bcw_len_lsb +: len_w]};
                    // zero length field stands for the full block
                    if (ln == '0) begin
                        ln = 13'(max_block_len);
                    end
                    next_s.count[s.sel] = ln;
                    next_s.caddr[s.sel] = mem_rdata[bcw_addr_lsb +: char_addr_w];
                    next_s.req = 1'b0;
                    next_s.done = 1'b1;
                    next_s.pc_out = s.pc_base + pc_step_ok;
                    next_s.seq = st_idle;
                end
            end
            st_save0: begin
                next_s.wait_cnt = s.wait_cnt - 16'h0001;
                if (mem_grant) begin
                    next_s.addr = s.addr + 16'h0001;
                    next_s.wdata = pack_bcw(s.count[s.sel], s.caddr[s.sel]);
                    next_s.seq = st_save1;
                end
            end
            st_save1: begin
                next_s.wait_cnt = s.wait_cnt - 16'h0001;
                if (mem_grant) begin
                    next_s.req = 1'b0;
                    next_s.we = 1'b0;
                    next_s.seq = st_wait;
                end
            end
            st_wait: begin
                if (s.wait_cnt == '0 || s.wait_cnt[15]) begin
                    next_s.done = 1'b1;
                    next_s.pc_out = s.pc_base + pc_step_busy;
                    next_s.seq = st_idle;
                end else begin
                    next_s.wait_cnt = s.wait_cnt - 16'h0001;
                end
            end
            default: begin
                next_s.seq = st_idle;
            end
        endcase
        // completion flags: set beats clear
        next_s.flag = done_evt | (s.flag & ~irq_clear);
        next_s.irq = |(next_s.flag & next_s.mask);
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            s <= '0;
        end else if (clk_en) begin
            s <= next_s;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign instr_done = s.done;
    assign next_pc = s.pc_out;
    assign mem_req = s.req;
    assign mem_we = s.we;
    assign mem_addr = s.addr;
    assign mem_wdata = s.wdata;
    assign chan_busy = s.busy;
    assign chan_abort = s.abort;
    assign irq_status = s.flag;
    assign irq = s.irq;
    always_comb begin
        for (int i = 0; i < chan_n; i++) begin
            chan_device[i*dev_w +: dev_w] = s.cmd[i][cmd_dev_lsb +: dev_w];
            chan_opcode[i*cmd_op_w +: cmd_op_w] = s.cmd[i][cmd_op_lsb +: cmd_op_w];
            chan_addr[i*char_addr_w +: char_addr_w] = s.caddr[i];
        end
    end
endmodule

// ---- sim/io_channel_initiator_monitor.sv ----
// Purpose: port checks on the i/o channel initiator
// Assumes: clk_en held high by the bench
// Notes: bound into every initiator instance
`timescale 1ns/10ps
module io_channel_initiator_monitor
    import io_channel_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // instruction side
    input wire logic start_channel_transfer,
    input wire logic [word_w-1:0] instr_word,
    input wire logic [15:0] instr_pc,
    input wire logic instr_done,
    input wire logic [15:0] next_pc,
    // memory and channels
    input wire logic mem_req,
    input wire logic mem_we,
    input wire logic [addr_w-1:0] mem_addr,
    input wire logic mem_grant,
    input wire logic [chan_n-1:0] chan_busy,
    input wire logic [chan_n*dev_w-1:0] chan_device,
    input wire logic [chan_n-1:0] chan_abort,
    input wire logic [chan_n-1:0] irq_clear,
    input wire logic [chan_n-1:0] irq_status,
    input wire logic irq
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [3:0] ch;
    logic go;
    assign ch = instr_word[23:20];
    assign go = start_channel_transfer;
    busy_pc_step_a:
        assert property (go && chan_busy[ch] |=> instr_done && next_pc == $past(instr_pc) + pc_step_busy)
            else $error("busy start pc step wrong");
    busy_keep_a:
        assert property (go && chan_busy[ch] |=> $stable(chan_device)) else $error("busy channel reloaded");
    fetch_addr_a:
        assert property (go && !chan_busy[ch] && !instr_word[19] && instr_word[18:17] == 2'h0
            |=> mem_req && !mem_we && mem_addr == $past(instr_word[15:0])) else $error("command fetch address wrong");
    busy_set_a:
        assert property (go && !chan_busy[ch] |=> chan_busy[$past(ch)]) else $error("channel not busy after start");
    hold_req_a:
        assert property (mem_req && !mem_grant |=> mem_req && $stable(mem_addr) && $stable(mem_we))
            else $error("memory request dropped");
    abort_pulse_a:
        assert property (chan_abort != '0 |=> chan_abort == '0 && (chan_busy & $past(chan_abort)) == '0)
            else $error("abort pulse or busy wrong");
    sticky_flag_a:
        assert property (!$past(rst) |-> ($past(irq_status) & ~irq_status & ~$past(irq_clear)) == '0)
            else $error("flag fell without clear");
    irq_quiet_a:
        assert property (irq_status == '0 [*2] |-> !irq) else $error("irq without flag");
    cover property (go && !chan_busy[ch]);
    cover property (go && chan_busy[ch]);
    cover property (irq);
endmodule
bind io_channel_initiator io_channel_initiator_monitor mon (.*);

// ---- sim/peripheral_adapter_model.sv ----
// Purpose: behavioural device adapters, one per channel
// Assumes: adapters stream once their channel reports busy
// Notes: uncounted channels end on their own; counted ones run until busy drops
`timescale 1ns/10ps
module peripheral_adapter_model (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst,
    // from the channels
    input wire logic [15:0] chan_busy,
    input wire logic [15:0] chan_abort,
    input wire logic [15:0] counted_mode,
    // to the channels
    output logic [15:0] chan_counted,
    output logic [15:0] chan_char,
    output logic [15:0] chan_word_access,
    output logic [15:0] chan_end
);
    logic [3:0] tick [16];
    logic [15:0] ended;
    assign chan_counted = counted_mode;
    always_ff @(posedge clk_sys) begin
        for (int i = 0; i < 16; i++) begin
            chan_char[i] <= 1'b0;
            chan_word_access[i] <= 1'b0;
            chan_end[i] <= 1'b0;
            if (rst || !chan_busy[i] || chan_abort[i]) begin
                tick[i] <= 4'h0;
                ended[i] <= 1'b0;
            end else if (!ended[i]) begin
                tick[i] <= (tick[i] == 4'hf) ? 4'h8 : tick[i] + 4'h1;
                // wait for the block word, then one character every second cycle
                chan_char[i] <= tick[i][3] & tick[i][0];
                chan_word_access[i] <= tick[i][3] & (tick[i][1:0] == 2'h3);
                if (!counted_mode[i] && tick[i] == 4'hc) begin
                    chan_end[i] <= 1'b1;
                    ended[i] <= 1'b1;
                end
            end
        end
    end
endmodule

// ---- sim/io_channel_initiator_tb.sv ----
// Purpose: self-checking bench for the i/o channel initiator
// Assumes: core memory grants every other cycle
// Notes: clk_en held high throughout
`timescale 1ns/10ps
module io_channel_initiator_tb;
    import io_channel_pkg::*;
    logic clk_sys, rst, clk_en, start_channel_transfer, save_channel_registers, abort_channel_transfer;
    logic instr_done, mem_req, mem_we, mem_grant, irq_mask_we, irq, irq_off;
    logic [word_w-1:0] instr_word, mem_wdata, mem_rdata;
    logic [15:0] instr_pc, index_value, next_pc, mem_addr;
    logic [chan_n-1:0] chan_busy, chan_abort, chan_counted, chan_char, chan_word_access, chan_end;
    logic [chan_n-1:0] irq_mask_wr, irq_clear, irq_status, counted_mode;
    logic [chan_n*dev_w-1:0] chan_device;
    logic [chan_n*cmd_op_w-1:0] chan_opcode;
    logic [chan_n*char_addr_w-1:0] chan_addr;
    logic [word_w-1:0] mem [65536];
    int fails, checks_done, took;
    io_channel_initiator uut (.*);
    peripheral_adapter_model adapters (.*);
    assign mem_rdata = mem[mem_addr];
    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end
    always @(posedge clk_sys) begin
        mem_grant <= mem_req & ~mem_grant;
        if (mem_req && mem_we && mem_grant) mem[mem_addr] <= mem_wdata;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        checks_done++;
        if (seen !== want) begin
            fails++;
            $display("ERROR %0t: saw %h wanted %h", $time, seen, want);
        end
    endtask
    task automatic give_verdict;
        if (fails == 0 && checks_done > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    // op bits: abort, save, start; x = {indirect, index}
    task automatic issue(input logic [2:0] op, input logic [3:0] ch, input logic [3:0] x, input logic [15:0] a,
                         input logic [15:0] pc);
        @(posedge clk_sys);
        {abort_channel_transfer, save_channel_registers, start_channel_transfer} <= op;
        instr_word <= {6'h0, ch, x, a};
        instr_pc <= pc;
        @(posedge clk_sys);
        {abort_channel_transfer, save_channel_registers, start_channel_transfer} <= 3'h0;
        took = 0;
        do begin
            @(negedge clk_sys);
            took++;
        end while (instr_done !== 1'b1 && took < 1000);
        check(took < 1000, 1);
    endtask
    task automatic wait_idle(input int ch);
        took = 0;
        while (chan_busy[ch] !== 1'b0 && took < 2000) begin
            @(negedge clk_sys);
            took++;
        end
        check(chan_busy[ch], 0);
    endtask
    task automatic set_mask(input logic [15:0] m);
        @(posedge clk_sys);
        irq_mask_we <= 1'b1;
        irq_mask_wr <= m;
        @(posedge clk_sys);
        irq_mask_we <= 1'b0;
        repeat (3) @(negedge clk_sys);
    endtask
    initial begin
        repeat (30000) @(posedge clk_sys);
        fails++;
        give_verdict();
    end
    initial begin
        {rst, clk_en, irq_mask_we, irq_mask_wr, irq_clear} = {2'h3, 33'h0};
        {start_channel_transfer, save_channel_registers, abort_channel_transfer} = 3'h0;
        {instr_word, instr_pc, index_value, fails, checks_done} = '0;
        counted_mode = 16'h0024;
        mem[16'h10] = {6'h05, 10'h02a, 14'h0};
        mem[16'h11] = {12'h020, 18'h20001};
        mem[16'h20] = 30'h30;
        mem[16'h30] = {6'h09, 10'h155, 14'h0};
        mem[16'h31] = {12'h010, 18'h20100};
        mem[16'h40] = {6'h03, 10'h001, 14'h0};
        mem[16'h41] = {12'h000, 18'h20200};
        repeat (8) @(posedge clk_sys);
        rst <= 1'b0;
        index_value <= 16'h0008;
        issue(3'h1, 4'h2, 4'h1, 16'h10, 16'h0040);
        check(next_pc, 16'h0042);
        check({chan_device[8 +: 4], chan_opcode[20 +: 10]}, 14'h142a);
        check(chan_addr[36 +: 18], 18'h20001);
        check(chan_busy[2], 1);
        issue(3'h1, 4'h2, 4'h0, 16'h30, 16'h0050);
        check({next_pc, chan_device[8 +: 4]}, 20'h00515);
        issue(3'h1, 4'h3, 4'h8, 16'h20, 16'h0060);
        check(chan_device[12 +: 4], 4'h9);
        issue(3'h1, 4'h4, 4'h2, 16'h08, 16'h0070);
        check({chan_busy[2], chan_device[16 +: 4]}, 5'h15);
        wait_idle(2);
        wait_idle(3);
        wait_idle(4);
        check(chan_addr[54 +: 18], 18'h20104);
        check(irq_status[4:2], 3'h7);
        set_mask(16'h0000);
        irq_off = irq;
        set_mask(16'hffff);
        check(irq ^ irq_off, 1);
        @(posedge clk_sys) irq_clear <= 16'h0004;
        @(posedge clk_sys) irq_clear <= 16'h0000;
        repeat (2) @(negedge clk_sys);
        check(irq_status[4:2], 3'h6);
        issue(3'h2, 4'h2, 4'h0, 16'h80, 16'h0080);
        check(took >= save_cycles - 8 && took <= save_cycles + 8, 1);
        check(mem[16'h80][27:14], 14'h142a);
        check(mem[16'h81][29:18], 12'h000);
        issue(3'h2, 4'h7, 4'h0, 16'h90, 16'h0090);
        check(mem[16'h90][27:24], 4'h0);
        issue(3'h1, 4'h5, 4'h0, 16'h40, 16'h00a0);
        repeat (100) @(negedge clk_sys);
        check(chan_busy[5], 1);
        issue(3'h4, 4'h5, 4'h0, 16'h0, 16'h00b0);
        check(took >= halt_cycles - 8 && took <= halt_cycles + 8, 1);
        check({chan_busy[5], chan_device[20 +: 4], irq_status[5]}, 6'h00);
        issue(3'h1, 4'h5, 4'h0, 16'h40, 16'h00c0);
        check({next_pc, chan_busy[5]}, 17'h00185);
        issue(3'h4, 4'h6, 4'h0, 16'h0, 16'h00d0);
        check(chan_busy[6], 0);
        give_verdict();
    end
endmodule
